// ---- hdl/ccr_bank.sv ----
// Clock control register bank: oscillator and PLL control, peripheral clock registers.
// Assumes an AXI4-Lite master on clk; oscillator and lock status pins are asynchronous,
// standby pulses and the calibration fuse value come from logic on clk.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module ccr_bank #(
	parameter int DRAIN_CYCLES = ccr_pkg::FAST_RC_DRAIN
) (
	input  wire logic                        clk,
	input  wire logic                        rst_b,
	input  wire logic [ccr_pkg::ADDR_W-1:0]  awaddr,
	input  wire logic [2:0]                  awprot,
	input  wire logic                        awvalid,
	output logic                             awready,
	input  wire logic [ccr_pkg::DATA_W-1:0]  wdata,
	input  wire logic [3:0]                  wstrb,
	input  wire logic                        wvalid,
	output logic                             wready,
	output logic [1:0]                       bresp,
	output logic                             bvalid,
	input  wire logic                        bready,
	input  wire logic [ccr_pkg::ADDR_W-1:0]  araddr,
	input  wire logic [2:0]                  arprot,
	input  wire logic                        arvalid,
	output logic                             arready,
	output logic [ccr_pkg::DATA_W-1:0]       rdata,
	output logic [1:0]                       rresp,
	output logic                             rvalid,
	input  wire logic                        rready,
	input  wire logic                        fastRcOkPin,
	input  wire logic                        pllLockPin,
	input  wire logic                        standbyEnter,
	input  wire logic                        standbyExit,
	input  wire logic [ccr_pkg::CAL_W-1:0]   fastRcCalFuse,
	output logic                             fastRcEnable,
	output logic [ccr_pkg::TRIM_W-1:0]       fastRcTrim,
	output logic [ccr_pkg::CAL_W-1:0]        fastRcCal,
	output logic                             pllEnable,
	output logic                             sysClkFromPll,
	output logic                             irq,
	output logic [ccr_pkg::DATA_W-1:0]       clkConfig0,
	output logic [ccr_pkg::DATA_W-1:0]       hsbClkEnable,
	output logic [ccr_pkg::DATA_W-1:0]       pb2ClkEnable,
	output logic [ccr_pkg::DATA_W-1:0]       pb1ClkEnable,
	output logic [ccr_pkg::DATA_W-1:0]       pb2Reset,
	output logic [ccr_pkg::DATA_W-1:0]       pb1Reset
);
	import ccr_pkg::*;

	generate
		if (DRAIN_CYCLES < 1 || DRAIN_CYCLES > 7) begin : g_chk
			$error("DRAIN_CYCLES must lie in 1..7");
		end
	endgenerate

	logic [31:0]       wrAddr_r;
	logic [31:0]       wrData_r;
	logic [3:0]        wrStrb_r;
	logic              doWrite;
	logic [31:0]       genReg_r [GEN_COUNT];
	logic              rcEn_r;
	logic              rcOk_r;
	logic [TRIM_W-1:0] trim_r;
	logic [CAL_W-1:0]  cal_r;
	logic              calLoaded_r;
	logic              pllEn_r;
	logic              pllLocked_r;
	logic [1:0]        okSync_r;
	logic [1:0]        lockSync_r;
	logic [3:0]        tickCnt_r;
	logic              fastTick;
	logic [2:0]        drainCnt_r;
	logic              rcOkPrev_r;
	logic              lockPrev_r;
	logic [IRQ_W-1:0]  irqStatus_r;
	logic [IRQ_W-1:0]  irqMask_r;
	logic [IRQ_W-1:0]  irqStatus_nxt;
	logic [IRQ_W-1:0]  irqEvent;
	logic [31:0]       ctrlWord;
	logic [31:0]       ctrlMerged;
	logic [31:0]       rdWord;
	logic              rdHit;
	logic              wrHit;
	logic              arTake;

	function automatic logic [31:0] mergeBytes(input logic [31:0] oldV,
			input logic [31:0] newV, input logic [3:0] strb);
		logic [31:0] res;
		res = oldV;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = newV[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Write channel: address and data are caught in either order, then applied together
	assign doWrite = !awready && !wready && !bvalid;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			awready  <= 1'b1;
			wready   <= 1'b1;
			bvalid   <= 1'b0;
			bresp    <= RESP_OKAY;
			wrAddr_r <= '0;
			wrData_r <= '0;
			wrStrb_r <= '0;
		end else begin
			if (awvalid && awready) begin
				awready  <= 1'b0;
				wrAddr_r <= awaddr;
			end
			if (wvalid && wready) begin
				wready   <= 1'b0;
				wrData_r <= wdata;
				wrStrb_r <= wstrb;
			end
			if (doWrite) begin
				bvalid <= 1'b1;
				bresp  <= wrHit ? RESP_OKAY : RESP_DECERR;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	always_comb begin
		wrHit = (wrAddr_r == ADDR_CTRL) || (wrAddr_r == ADDR_IRQ_STATUS) ||
			(wrAddr_r == ADDR_IRQ_MASK);
		for (int i = 0; i < GEN_COUNT; i++) begin
			if (wrAddr_r == GEN_ADDR[i]) begin
				wrHit = 1'b1;
			end
		end
	end

	// Plain storage registers; only the CFG0 PLL select bit is decoded here, for sysClkFromPll
	generate
		for (genvar g = 0; g < GEN_COUNT; g++) begin : g_gen
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					genReg_r[g] <= GEN_RESET[g];
				end else if (doWrite && wrAddr_r == GEN_ADDR[g]) begin
					genReg_r[g] <= mergeBytes(genReg_r[g], wrData_r, wrStrb_r);
				end
			end
		end
	endgenerate

	always_comb begin
		ctrlWord = '0;
		ctrlWord[CTL_RC_EN_BIT] = rcEn_r;
		ctrlWord[CTL_RC_OK_BIT] = rcOk_r;
		ctrlWord[CTL_TRIM_LSB +: TRIM_W] = trim_r;
		ctrlWord[CTL_CAL_LSB +: CAL_W] = cal_r;
		ctrlWord[CTL_PLL_EN_BIT] = pllEn_r;
		ctrlWord[CTL_PLL_LOCK_BIT] = pllLocked_r;
	end

	// Only writable fields are taken from the merge
	assign ctrlMerged = mergeBytes(ctrlWord, wrData_r, wrStrb_r) & CTRL_WR_MASK;

	// Standby pulses override a software write in the same cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rcEn_r  <= RC_EN_RESET;
			trim_r  <= TRIM_RESET;
			pllEn_r <= 1'b0;
		end else begin
			if (doWrite && wrAddr_r == ADDR_CTRL) begin
				rcEn_r  <= ctrlMerged[CTL_RC_EN_BIT];
				trim_r  <= ctrlMerged[CTL_TRIM_LSB +: TRIM_W];
				pllEn_r <= ctrlMerged[CTL_PLL_EN_BIT];
			end
			if (standbyExit) begin
				rcEn_r <= 1'b1;
			end
			if (standbyEnter) begin
				pllEn_r <= 1'b0;
			end
		end
	end

	// Fuse value is static; caught once after reset release
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cal_r       <= '0;
			calLoaded_r <= 1'b0;
		end else if (!calLoaded_r) begin
			cal_r       <= fastRcCalFuse;
			calLoaded_r <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			// Held at the stable flag's reset level, so no false ready edge follows reset
			okSync_r   <= {2{RC_OK_RESET}};
			lockSync_r <= '0;
		end else begin
			okSync_r   <= {okSync_r[0], fastRcOkPin};
			lockSync_r <= {lockSync_r[0], pllLockPin};
		end
	end

	// One pulse per oscillator period, rounded up so the drain is never short
	assign fastTick = (tickCnt_r == 4'(FAST_RC_CYC - 1));

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tickCnt_r <= '0;
		end else if (rcEn_r || fastTick) begin
			tickCnt_r <= '0;
		end else begin
			tickCnt_r <= tickCnt_r + 4'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rcOk_r     <= RC_OK_RESET;
			drainCnt_r <= '0;
		end else if (rcEn_r) begin
			rcOk_r     <= okSync_r[1];
			drainCnt_r <= '0;
		end else if (rcOk_r && fastTick) begin
			if (drainCnt_r == 3'(DRAIN_CYCLES - 1)) begin
				rcOk_r <= 1'b0;
			end
			drainCnt_r <= drainCnt_r + 3'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pllLocked_r   <= 1'b0;
			sysClkFromPll <= 1'b0;
		end else begin
			pllLocked_r   <= pllEn_r && lockSync_r[1];
			sysClkFromPll <= pllLocked_r && genReg_r[GEN_CFG0][CFG0_PLL_SEL_BIT];
		end
	end

	// Interrupt status: set wins over the read that clears it
	assign arTake = arvalid && arready;
	assign irqEvent[IRQ_RC_READY_BIT] = rcOk_r && !rcOkPrev_r;
	assign irqEvent[IRQ_PLL_LOCK_BIT] = pllLocked_r && !lockPrev_r;

	always_comb begin
		irqStatus_nxt = irqStatus_r;
		if (arTake && araddr == ADDR_IRQ_STATUS) begin
			irqStatus_nxt = '0;
		end
		irqStatus_nxt = irqStatus_nxt | irqEvent;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rcOkPrev_r  <= RC_OK_RESET;
			lockPrev_r  <= 1'b0;
			irqStatus_r <= '0;
			irqMask_r   <= '0;
			irq         <= 1'b0;
		end else begin
			rcOkPrev_r  <= rcOk_r;
			lockPrev_r  <= pllLocked_r;
			irqStatus_r <= irqStatus_nxt;
			irq         <= |(irqStatus_nxt & irqMask_r);
			if (doWrite && wrAddr_r == ADDR_IRQ_MASK && wrStrb_r[0]) begin
				irqMask_r <= wrData_r[IRQ_W-1:0];
			end
		end
	end

	// Read channel: one-cycle answer, data captured when the address is taken
	always_comb begin
		rdWord = '0;
		rdHit  = 1'b1;
		if (araddr == ADDR_CTRL) begin
			rdWord = ctrlWord & CTRL_RD_MASK;
		end else if (araddr == ADDR_IRQ_STATUS) begin
			rdWord[IRQ_W-1:0] = irqStatus_r;
		end else if (araddr == ADDR_IRQ_MASK) begin
			rdWord[IRQ_W-1:0] = irqMask_r;
		end else begin
			rdHit = 1'b0;
			for (int i = 0; i < GEN_COUNT; i++) begin
				if (araddr == GEN_ADDR[i]) begin
					rdWord = genReg_r[i];
					rdHit  = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= RESP_OKAY;
		end else if (arTake) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rdWord;
			rresp   <= rdHit ? RESP_OKAY : RESP_DECERR;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	assign fastRcEnable = rcEn_r;
	assign fastRcTrim   = trim_r;
	assign fastRcCal    = cal_r;
	assign pllEnable    = pllEn_r;
	assign clkConfig0   = genReg_r[GEN_CFG0];
	assign hsbClkEnable = genReg_r[GEN_HSB_EN];
	assign pb2ClkEnable = genReg_r[GEN_PB2_EN];
	assign pb1ClkEnable = genReg_r[GEN_PB1_EN];
	assign pb2Reset     = genReg_r[GEN_PB2_RST];
	assign pb1Reset     = genReg_r[GEN_PB1_RST];

	// Helper: cycles spent with the oscillator disabled
	logic [7:0] offCnt_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			offCnt_r <= '0;
		end else if (rcEn_r) begin
			offCnt_r <= '0;
		end else if (offCnt_r != 8'hFF) begin
			offCnt_r <= offCnt_r + 8'h1;
		end
	end

	localparam int DRAIN_MIN = FAST_RC_DRAIN * FAST_RC_CYC - 1;

	sequence s_ctrlWrite;
		doWrite && wrAddr_r == ADDR_CTRL && wrStrb_r[0] && !standbyExit;
	endsequence
	sequence s_readTake;
		arvalid && arready;
	endsequence

	a_rc_en_write: assert property (@(posedge clk) disable iff (!rst_b)
		s_ctrlWrite |=> fastRcEnable == $past(wrData_r[CTL_RC_EN_BIT]))
		else $error("oscillator enable not written");
	a_standby_exit: assert property (@(posedge clk) disable iff (!rst_b)
		standbyExit |=> fastRcEnable) else $error("standby exit left oscillator off");
	a_stable_drain: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(rcOk_r) && DRAIN_CYCLES == FAST_RC_DRAIN |-> offCnt_r >= DRAIN_MIN)
		else $error("stable flag fell too early");
	a_trim_write: assert property (@(posedge clk) disable iff (!rst_b)
		s_ctrlWrite |=> fastRcTrim == $past(wrData_r[CTL_TRIM_LSB +: TRIM_W]))
		else $error("trim not written");
	a_cal_frozen: assert property (@(posedge clk) disable iff (!rst_b)
		calLoaded_r |=> $stable(fastRcCal)) else $error("calibration changed");
	a_pll_standby: assert property (@(posedge clk) disable iff (!rst_b)
		standbyEnter |=> !pllEnable ##1 !pllLocked_r) else $error("PLL kept on");
	a_lock_needs_en: assert property (@(posedge clk) disable iff (!rst_b)
		pllLocked_r |-> $past(pllEn_r)) else $error("lock without enable");
	a_pll_route: assert property (@(posedge clk) disable iff (!rst_b)
		sysClkFromPll |-> $past(pllLocked_r)) else $error("PLL routed unlocked");
	a_ready_irq: assert property (@(posedge clk) disable iff (!rst_b)
		irqEvent[IRQ_RC_READY_BIT] && irqMask_r[IRQ_RC_READY_BIT] |=> irq)
		else $error("ready interrupt missing");
	a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b)
		s_readTake ##0 (araddr == ADDR_CTRL) |=> rvalid && (rdata & ~CTRL_RD_MASK) == '0)
		else $error("reserved bits read nonzero");
	a_map_decode: assert property (@(posedge clk) disable iff (!rst_b)
		s_readTake ##0 (araddr == GEN_ADDR[GEN_HSB_EN]) |=> rresp == RESP_OKAY)
		else $error("clock enable register not decoded");
endmodule // ccr_bank

// ---- hdl/ccr_pkg.sv ----
// Constants of the clock control register bank: map, fields, reset values, timing.
// Assumes a 250 MHz bus clock and byte addresses on an AXI4-Lite slave port.
package ccr_pkg;
	localparam int          ADDR_W           = 32;
	localparam int          DATA_W           = 32;
	localparam int          TRIM_W           = 5;
	localparam int          CAL_W            = 8;
	localparam int          IRQ_W            = 2;
	localparam int          GEN_COUNT        = 8;
	localparam logic [31:0] ADDR_CTRL        = 32'h40021000;
	localparam logic [31:0] ADDR_IRQ_STATUS  = 32'h40021030;
	localparam logic [31:0] ADDR_IRQ_MASK    = 32'h40021034;
	localparam logic [31:0] GEN_ADDR [GEN_COUNT] = '{
		32'h40021004, 32'h40021008, 32'h4002100C, 32'h40021010,
		32'h40021014, 32'h40021018, 32'h4002101C, 32'h40021024};
	localparam logic [31:0] GEN_RESET [GEN_COUNT] = '{
		32'h00000020, 32'h00000000, 32'h00000000, 32'h00000000,
		32'h00000004, 32'h00000000, 32'h00000000, 32'h0C000000};
	localparam int          GEN_CFG0         = 0;
	localparam int          GEN_INTR         = 1;
	localparam int          GEN_PB2_RST      = 2;
	localparam int          GEN_PB1_RST      = 3;
	localparam int          GEN_HSB_EN       = 4;
	localparam int          GEN_PB2_EN       = 5;
	localparam int          GEN_PB1_EN       = 6;
	localparam int          CTL_RC_EN_BIT    = 0;
	localparam int          CTL_RC_OK_BIT    = 1;
	localparam int          CTL_TRIM_LSB     = 3;
	localparam int          CTL_CAL_LSB      = 8;
	localparam int          CTL_PLL_EN_BIT   = 24;
	localparam int          CTL_PLL_LOCK_BIT = 25;
	localparam int          CFG0_PLL_SEL_BIT = 1;
	localparam int          IRQ_RC_READY_BIT = 0;
	localparam int          IRQ_PLL_LOCK_BIT = 1;
	localparam logic        RC_EN_RESET      = 1'b1;
	localparam logic        RC_OK_RESET      = 1'b1;
	localparam logic [4:0]  TRIM_RESET       = 5'h10;
	localparam logic [31:0] CTRL_WR_MASK     = 32'h010000F9;
	localparam logic [31:0] CTRL_RD_MASK     = 32'h0300FFFB;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_DECERR      = 2'h3;
	localparam int          CLK_FREQ_KHZ     = 250000;
	localparam int          FAST_RC_FREQ_KHZ = 24000;
	localparam int          FAST_RC_CYC      =
		(CLK_FREQ_KHZ + FAST_RC_FREQ_KHZ - 1) / FAST_RC_FREQ_KHZ;
	localparam int          FAST_RC_DRAIN    = 6;
endpackage

// ---- verif/tb.sv ----
// Self-checking bench for the clock control register bank.
// Assumes the bank alone on one clock; the bench drives every input itself, the registers over AXI4-Lite.
`timescale 1ns/1ps
`define CHK(got, exp) begin numChecks++; if ((got) !== (exp)) begin numErrors++; \
	$display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb;
	import ccr_pkg::*;
	typedef struct {
		logic        wr;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0]  strb;
		logic [31:0] rd;
		logic [1:0]  resp;
	} ccr_row_t;
	logic        clk;
	logic        rst_b;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [31:0] clkConfig0, hsbClkEnable, pb2ClkEnable, pb1ClkEnable, pb2Reset, pb1Reset;
	logic [2:0]  awprot, arprot;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic        fastRcOkPin, pllLockPin, standbyEnter, standbyExit;
	logic [7:0]  fastRcCalFuse, fastRcCal;
	logic [4:0]  fastRcTrim;
	logic        fastRcEnable, pllEnable, sysClkFromPll, irq;
	logic [31:0] rdVal;
	int          numErrors = 0;
	int          numChecks = 0;
	int          k;
	// Plain rows: reset values, byte lanes, read-only bits, an unmapped hole
	ccr_row_t rows [14] = '{
		'{1'b0, 32'h40021000, 32'h00000000, 4'hF, 32'h00005A83, 2'h0},
		'{1'b0, 32'h40021004, 32'h00000000, 4'hF, 32'h00000020, 2'h0},
		'{1'b0, 32'h40021014, 32'h00000000, 4'hF, 32'h00000004, 2'h0},
		'{1'b0, 32'h40021024, 32'h00000000, 4'hF, 32'h0C000000, 2'h0},
		'{1'b0, 32'h40021008, 32'h00000000, 4'hF, 32'h00000000, 2'h0},
		'{1'b1, 32'h4002100C, 32'h12345678, 4'hF, 32'h12345678, 2'h0},
		'{1'b1, 32'h40021010, 32'h87654321, 4'hF, 32'h87654321, 2'h0},
		'{1'b1, 32'h40021014, 32'hFFFFFFFF, 4'h1, 32'h000000FF, 2'h0},
		'{1'b1, 32'h40021018, 32'hA5A5A5A5, 4'hC, 32'hA5A50000, 2'h0},
		'{1'b1, 32'h4002101C, 32'h0000FFFF, 4'h3, 32'h0000FFFF, 2'h0},
		'{1'b1, 32'h40021000, 32'hFFFFFFFF, 4'hF, 32'h01005AFB, 2'h0},
		'{1'b1, 32'h40021000, 32'h00000081, 4'hF, 32'h00005A83, 2'h0},
		'{1'b1, 32'h40021020, 32'h00000001, 4'hF, 32'h00000000, 2'h3},
		'{1'b1, 32'h40021004, 32'h00000022, 4'hF, 32'h00000022, 2'h0}};

	ccr_bank i_ccr_bank (
		.clk, .rst_b, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .fastRcOkPin, .pllLockPin, .standbyEnter, .standbyExit,
		.fastRcCalFuse, .fastRcEnable, .fastRcTrim, .fastRcCal, .pllEnable, .sysClkFromPll,
		.irq, .clkConfig0, .hsbClkEnable, .pb2ClkEnable, .pb1ClkEnable, .pb2Reset, .pb1Reset);

	always #2 clk = ~clk;

	task automatic testDone();
		if (numErrors == 0 && numChecks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic timeOut();
		numErrors++;
		$display("wrong value at %0t: handshake wait ran out", $time);
		testDone();
	endtask

	// Lets the edge's own updates land before outputs are looked at
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic axiWrite(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		int n;
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		r = 2'h2;
		for (n = 0; n < 64; n++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (n == 64) timeOut();
	endtask

	task automatic axiRead(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (n == 64) timeOut();
	endtask

	task automatic readExpect(input logic [31:0] a, input logic [31:0] e);
		axiRead(a, rdVal, resp);
		`CHK(rdVal, e)
	endtask

	initial begin
		{clk, rst_b, awaddr, wdata, araddr, awprot, arprot, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready, pllLockPin, standbyEnter, standbyExit} = '0;
		fastRcOkPin   = 1'b1;
		fastRcCalFuse = 8'h5A;
		settle(3);
		`CHK(fastRcEnable, 1'b1)
		`CHK(fastRcTrim, 5'h10)
		`CHK(pllEnable, 1'b0)
		`CHK(clkConfig0, 32'h00000020)
		`CHK(hsbClkEnable, 32'h00000004)
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		for (k = 0; k < 14; k++) begin
			if (rows[k].wr) begin
				axiWrite(rows[k].addr, rows[k].wdata, rows[k].strb, resp);
				`CHK(resp, rows[k].resp)
			end
			axiRead(rows[k].addr, rdVal, resp);
			`CHK(rdVal, rows[k].rd)
			`CHK(resp, rows[k].resp)
		end
		settle(1);
		`CHK(pb2Reset, 32'h12345678)
		`CHK(pb1Reset, 32'h87654321)
		`CHK(pb2ClkEnable, 32'hA5A50000)
		`CHK(pb1ClkEnable, 32'h0000FFFF)
		`CHK(hsbClkEnable, 32'h000000FF)
		`CHK(fastRcCal, 8'h5A)
		`CHK(fastRcTrim, 5'h10)
		// Oscillator off: stable flag lingers for the drain time, then drops
		axiWrite(ADDR_CTRL, 32'h00000080, 4'hF, resp);
		settle(40);
		`CHK(fastRcEnable, 1'b0)
		readExpect(ADDR_CTRL, 32'h00005A82);
		settle(30);
		readExpect(ADDR_CTRL, 32'h00005A80);
		// Unmasked ready event through a standby exit
		axiWrite(ADDR_IRQ_MASK, 32'h00000001, 4'hF, resp);
		readExpect(ADDR_IRQ_MASK, 32'h00000001);
		readExpect(ADDR_IRQ_STATUS, 32'h00000000);
		`CHK(irq, 1'b0)
		@(posedge clk);
		standbyExit <= 1'b1;
		@(posedge clk);
		standbyExit <= 1'b0;
		#1;
		`CHK(fastRcEnable, 1'b1)
		for (k = 0; k < 20 && irq !== 1'b1; k++) @(posedge clk);
		`CHK(irq, 1'b1)
		readExpect(ADDR_IRQ_STATUS, 32'h00000001);
		settle(1);
		`CHK(irq, 1'b0)
		// Lock gates the system clock switch; masked lock event keeps irq low
		axiWrite(ADDR_CTRL, 32'h01000081, 4'hF, resp);
		settle(4);
		`CHK(pllEnable, 1'b1)
		`CHK(sysClkFromPll, 1'b0)
		@(posedge clk);
		pllLockPin <= 1'b1;
		settle(6);
		`CHK(sysClkFromPll, 1'b1)
		`CHK(irq, 1'b0)
		readExpect(ADDR_CTRL, 32'h03005A83);
		readExpect(ADDR_IRQ_STATUS, 32'h00000002);
		@(posedge clk);
		standbyEnter <= 1'b1;
		@(posedge clk);
		standbyEnter <= 1'b0;
		#1;
		`CHK(pllEnable, 1'b0)
		settle(4);
		`CHK(sysClkFromPll, 1'b0)
		readExpect(ADDR_CTRL, 32'h00005A83);
		// Reset in mid-run restores the reset values
		@(posedge clk);
		pllLockPin <= 1'b0;
		rst_b      <= 1'b0;
		settle(2);
		`CHK(pb2Reset, 32'h00000000)
		`CHK(clkConfig0, 32'h00000020)
		`CHK(fastRcTrim, 5'h10)
		@(posedge clk);
		rst_b <= 1'b1;
		settle(2);
		`CHK(fastRcEnable, 1'b1)
		`CHK(irq, 1'b0)
		readExpect(ADDR_CTRL, 32'h00005A83);
		readExpect(ADDR_IRQ_STATUS, 32'h00000000);
		testDone();
	end
endmodule // tb
